// file: src/tbtr_top.sv
// tbtr_top: timebases, reference selection and shared trigger line routing
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module tbtr_top
  import tbtr_pkg::*;
#(
  parameter int FILT_LONG_CNT = FILT_LONG_N
)
(
  input  wire logic                aclk,          // 40 MHz clock, onboard oscillator
  input  wire logic                aresetn,       // sync reset, active low
  input  wire logic [7:0]          s_axi_awaddr,  // write address
  input  wire logic [2:0]          s_axi_awprot,  // unused
  input  wire logic                s_axi_awvalid, // write address valid
  output logic                     s_axi_awready, // write address ready
  input  wire logic [31:0]         s_axi_wdata,   // write data
  input  wire logic [3:0]          s_axi_wstrb,   // byte enables
  input  wire logic                s_axi_wvalid,  // write data valid
  output logic                     s_axi_wready,  // write data ready
  output logic [1:0]               s_axi_bresp,   // write response
  output logic                     s_axi_bvalid,  // write response valid
  input  wire logic                s_axi_bready,  // write response ready
  input  wire logic [7:0]          s_axi_araddr,  // read address
  input  wire logic [2:0]          s_axi_arprot,  // unused
  input  wire logic                s_axi_arvalid, // read address valid
  output logic                     s_axi_arready, // read address ready
  output logic [31:0]              s_axi_rdata,   // read data
  output logic [1:0]               s_axi_rresp,   // read response
  output logic                     s_axi_rvalid,  // read data valid
  input  wire logic                s_axi_rready,  // read data ready
  input  wire logic [TRIG_N-1:0]   trig_i,        // shared trigger line levels
  output logic [TRIG_N-1:0]        trig_o,        // shared trigger line drive
  output logic [TRIG_N-1:0]        trig_oe,       // high while driving line
  input  wire logic [FRONT_N-1:0]  front_i,       // front function terminals
  output logic [FRONT_N-1:0]       front_fwd_o,   // line forwarded to terminal
  output logic [FRONT_N-1:0]       front_fwd_oe,  // terminal forward enable
  input  wire logic                star_i,        // star trigger line
  input  wire logic                bp10_i,        // backplane 10 MHz clock
  input  wire logic [TSIG_N-1:0]   tim_sig_i,     // internal timing signals
  output logic                     pll_ref_o,     // selected external reference
  output logic                     pll_lock_o,    // reference edges present
  output logic                     tb20_tick_o,   // 20 MHz timebase pulse
  output logic                     tb100k_tick_o, // 100 kHz timebase pulse
  output logic [1:0]               ctr0_inc_o,    // counter 0 source counts
  output logic [1:0]               ctr1_inc_o,    // counter 1 source counts
  output logic                     ref10_o,       // 10 MHz reference clock
  output logic [DEST_N-1:0]        dest_o         // routed timing destinations
);
  logic [CTRL_W-1:0]        ctrl_r;
  logic [TRIG_N-1:0]        trig_oe_r;
  logic [63:0]              tsel_r;
  logic [2*FIN_N-1:0]       filt_r;
  logic [4*FRONT_N-1:0]     front_r;
  logic [DCFG_W-1:0]        dest_cfg_r [DEST_N];
  logic [PIN_N-1:0]         meta_r;
  logic [PIN_N-1:0]         sync_r;
  logic [FIN_N-1:0]         filt_w;
  logic                     ref_prev_r;
  logic [4:0]               lock_cnt_r;
  logic                     tb_run;
  logic                     tb20_ph_r;
  logic [7:0]               tb100k_cnt_r;
  logic [1:0]               ref_div_r;
  logic [TSRC_N-1:0]        tsrc_w;
  logic                     aw_got_r;
  logic                     w_got_r;
  logic [7:0]               awaddr_r;
  logic [31:0]              wdata_r;
  logic [3:0]               wstrb_r;
  logic                     do_wr;
  logic [32:0]              wr_old_w;
  logic [32:0]              rd_w;
  logic [31:0]              wr_val_w;
  logic [5:0]               wr_didx;
  logic [3:0]               ref_src;

  // reads a register word; top bit flags a mapped address
  function automatic logic [32:0] reg_rd(input logic [7:0] a);
    logic [5:0] di;
    di = a[7:2] - DEST_WORD0;
    if (a == ADDR_CTRL)
      reg_rd = {1'b1, 20'h0, ctrl_r};
    else if (a == ADDR_STATUS)
      reg_rd = {1'b1, 8'h0, sync_r[7:0], filt_w[7:0], 6'h0, tb_run, pll_lock_o};
    else if (a == ADDR_TRIG_OE)
      reg_rd = {1'b1, 24'h0, trig_oe_r};
    else if (a == ADDR_TSEL_LO)
      reg_rd = {1'b1, tsel_r[31:0]};
    else if (a == ADDR_TSEL_HI)
      reg_rd = {1'b1, tsel_r[63:32]};
    else if (a == ADDR_FILT)
      reg_rd = {1'b1, 2'h0, filt_r};
    else if (a == ADDR_FRONT)
      reg_rd = {1'b1, 8'h0, front_r};
    else if (a >= ADDR_DEST0 && a[1:0] == 2'h0 && di < 6'(DEST_N))
      reg_rd = {1'b1, 26'h0, dest_cfg_r[di[3:0]]};
    else
      reg_rd = {1'b0, 32'h0};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] st);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++)
      if (st[b])
        m[8*b +: 8] = n[8*b +: 8];
    merge = m;
  endfunction

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign do_wr         = aw_got_r && w_got_r;
  assign wr_val_w      = merge(wr_old_w[31:0], wdata_r, wstrb_r);
  assign wr_didx       = awaddr_r[7:2] - DEST_WORD0;

  // always_comb so the registers read inside the function stay in the sensitivity
  always_comb
    wr_old_w = reg_rd(awaddr_r);

  always_comb
    rd_w = reg_rd(s_axi_araddr);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      else if (do_wr)
        aw_got_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      else if (do_wr)
        w_got_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_old_w[32] ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // register file; status is read-only and ignores writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r    <= '0;
      trig_oe_r <= '0;
      tsel_r    <= '0;
      filt_r    <= '0;
      front_r   <= '0;
      for (int d = 0; d < DEST_N; d++)
        dest_cfg_r[d] <= '0;
    end
    else if (do_wr)
    begin
      if (awaddr_r == ADDR_CTRL)
        ctrl_r <= wr_val_w[CTRL_W-1:0];
      else if (awaddr_r == ADDR_TRIG_OE)
        trig_oe_r <= wr_val_w[TRIG_N-1:0];
      else if (awaddr_r == ADDR_TSEL_LO)
        tsel_r[31:0] <= wr_val_w;
      else if (awaddr_r == ADDR_TSEL_HI)
        tsel_r[63:32] <= wr_val_w;
      else if (awaddr_r == ADDR_FILT)
        filt_r <= wr_val_w[2*FIN_N-1:0];
      else if (awaddr_r == ADDR_FRONT)
        front_r <= wr_val_w[4*FRONT_N-1:0];
      else if (awaddr_r >= ADDR_DEST0 && wr_old_w[32])
        dest_cfg_r[wr_didx[3:0]] <= wr_val_w[DCFG_W-1:0];
    end
  end

  // read channel
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_w[31:0];
      s_axi_rresp  <= rd_w[32] ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // pins come from other boards; two flops before any use
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= {bp10_i, star_i, front_i, trig_i};
      sync_r <= meta_r;
    end
  end

  // external reference select feeds the pll and the lock watch
  assign ref_src = ctrl_r[CTRL_SRC_LSB +: 4];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pll_ref_o  <= 1'b0;
      ref_prev_r <= 1'b0;
      lock_cnt_r <= LOCK_WIN;
      pll_lock_o <= 1'b0;
    end
    else
    begin
      if (ref_src < 4'(TRIG_N))
        pll_ref_o <= sync_r[ref_src];
      else if (ref_src == REF_BP10)
        pll_ref_o <= sync_r[PIN_BP10];
      else if (ref_src == REF_STAR)
        pll_ref_o <= sync_r[PIN_STAR];
      else
        pll_ref_o <= 1'b0;
      ref_prev_r <= pll_ref_o;
      if (pll_ref_o && !ref_prev_r)
        lock_cnt_r <= 5'h00;
      else if (lock_cnt_r < LOCK_WIN)
        lock_cnt_r <= lock_cnt_r + 5'h01;
      pll_lock_o <= (lock_cnt_r < LOCK_WIN);
    end
  end

  // onboard oscillator always runs; external needs lock first
  assign tb_run = !ctrl_r[CTRL_EXT_BIT] || pll_lock_o;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tb20_ph_r     <= 1'b0;
      tb20_tick_o   <= 1'b0;
      tb100k_cnt_r  <= 8'h00;
      tb100k_tick_o <= 1'b0;
    end
    else
    begin
      if (ctrl_r[CTRL_EXT_BIT] && pll_ref_o && !ref_prev_r)
        tb20_ph_r <= 1'b1;
      else if (tb_run)
        tb20_ph_r <= !tb20_ph_r;
      tb20_tick_o   <= tb_run && tb20_ph_r;
      tb100k_tick_o <= tb_run && tb20_ph_r && tb100k_cnt_r == TB100K_LAST;
      if (tb_run && tb20_ph_r)
        tb100k_cnt_r <= (tb100k_cnt_r == TB100K_LAST) ? 8'h00 : tb100k_cnt_r + 8'h01;
    end
  end

  // counter sources as counts per clock; two 80 MHz edges per cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctr0_inc_o <= 2'h0;
      ctr1_inc_o <= 2'h0;
    end
    else
    begin
      case (ctrl_r[CTRL_C0_LSB +: 2])
        CSRC_TB80:   ctr0_inc_o <= tb_run ? TB80_PER_CLK : 2'h0;
        CSRC_TB20:   ctr0_inc_o <= {1'b0, tb_run && tb20_ph_r};
        CSRC_TB100K: ctr0_inc_o <= {1'b0, tb_run && tb20_ph_r && tb100k_cnt_r == TB100K_LAST};
        default:     ctr0_inc_o <= 2'h0;
      endcase
      case (ctrl_r[CTRL_C1_LSB +: 2])
        CSRC_TB80:   ctr1_inc_o <= tb_run ? TB80_PER_CLK : 2'h0;
        CSRC_TB20:   ctr1_inc_o <= {1'b0, tb_run && tb20_ph_r};
        CSRC_TB100K: ctr1_inc_o <= {1'b0, tb_run && tb20_ph_r && tb100k_cnt_r == TB100K_LAST};
        default:     ctr1_inc_o <= 2'h0;
      endcase
    end
  end

  // 10 MHz reference from the oscillator, independent of the pll
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ref_div_r <= 2'h0;
    else
      ref_div_r <= ref_div_r + 2'h1;
  end
  assign ref10_o = ref_div_r[1];

  // unfiltered fronts go out directly; listed clocks leave active low
  assign tsrc_w = {sync_r[8 +: FRONT_N], ref10_o, tim_sig_i ^ TSIG_INV_MASK};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trig_o       <= '0;
      trig_oe      <= '0;
      front_fwd_o  <= '0;
      front_fwd_oe <= '0;
    end
    else
    begin
      trig_oe <= trig_oe_r;
      for (int t = 0; t < TRIG_N; t++)
        trig_o[t] <= (tsel_r[8*t +: 5] < 5'(TSRC_N)) ? tsrc_w[tsel_r[8*t +: 5]] : 1'b0;
      for (int f = 0; f < FRONT_N; f++)
      begin
        front_fwd_oe[f] <= front_r[4*f+3];
        front_fwd_o[f]  <= sync_r[front_r[4*f +: 3]];
      end
    end
  end

  // filters, one per input except the backplane clock, and destination routing, one per destination
  for (genvar g = 0; g < FIN_N; g++)
  begin : g_filt
    tbtr_filter #(
      .LONG_N (FILT_LONG_CNT)
    ) u_filt (
      .aclk    (aclk),
      .aresetn (aresetn),
      .smp_i   (sync_r[g]),
      .set_i   (filt_r[2*g +: 2]),
      .filt_o  (filt_w[g])
    );
  end

  for (genvar d = 0; d < DEST_N; d++)
  begin : g_dest
    logic lvl;
    logic lvl_prev_r;
    assign lvl = ((dest_cfg_r[d][3:0] < 4'(FIN_N)) ? filt_w[dest_cfg_r[d][3:0]] : 1'b0)
                 ^ dest_cfg_r[d][DCFG_INV_BIT];
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        lvl_prev_r <= 1'b0;
        dest_o[d]  <= 1'b0;
      end
      else
      begin
        lvl_prev_r <= lvl;
        dest_o[d]  <= dest_cfg_r[d][DCFG_EDGE_BIT] ? (lvl && !lvl_prev_r) : lvl;
      end
    end
  end

  logic [7:0] h_tb20_r;
  logic       h_seen_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      h_tb20_r <= 8'h00;
      h_seen_r <= 1'b0;
    end
    else if (tb100k_tick_o)
    begin
      h_tb20_r <= 8'h00;
      h_seen_r <= 1'b1;
    end
    else if (tb20_tick_o)
      h_tb20_r <= h_tb20_r + 8'h01;
  end

  a_tb20_period: assert property (@(posedge aclk) disable iff (!aresetn || ctrl_r[CTRL_EXT_BIT])
    tb20_tick_o |=> !tb20_tick_o ##1 tb20_tick_o)
    else $error("20 MHz tick not every second cycle");
  a_tb100k_gap: assert property (@(posedge aclk) disable iff (!aresetn)
    (tb100k_tick_o && h_seen_r) |-> (h_tb20_r == TB100K_LAST))
    else $error("100 kHz tick not every 200 ticks of 20 MHz");
  a_ref10_shape: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(ref10_o) |=> ref10_o ##1 !ref10_o ##1 !ref10_o ##1 ref10_o)
    else $error("10 MHz reference not a divide by four");
  a_ctr_tb80_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_r[CTRL_C0_LSB +: 2] == CSRC_TB80 && tb_run) |=> (ctr0_inc_o == TB80_PER_CLK))
    else $error("counter 0 not fed at 80 MHz rate");
  a_ext_bp10_src: assert property (@(posedge aclk) disable iff (!aresetn)
    (ref_src == REF_BP10) |=> (pll_ref_o == $past(sync_r[PIN_BP10])))
    else $error("backplane clock not selected as reference");
  a_unlock_stall: assert property (@(posedge aclk) disable iff (!aresetn)
    (ctrl_r[CTRL_EXT_BIT] && !pll_lock_o) |=> !tb20_tick_o && !tb100k_tick_o)
    else $error("timebase ran without reference lock");
  a_conv_inverted: assert property (@(posedge aclk) disable iff (!aresetn)
    (tsel_r[4:0] == TSRC_CONV) |=> (trig_o[0] == !$past(tim_sig_i[2])))
    else $error("convert clock not inverted on line 0");
  a_front_raw_fwd: assert property (@(posedge aclk) disable iff (!aresetn)
    front_r[3] |=> (front_fwd_oe[0] && front_fwd_o[0] == $past(sync_r[front_r[2:0]])))
    else $error("front terminal forward not unfiltered");
endmodule

// file: src/tbtr_pkg.sv
// tbtr_pkg: constants for timebase generation and shared trigger routing
package tbtr_pkg;
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          TRIG_N        = 8;
  localparam int          FRONT_N       = 6;
  localparam int          PIN_N         = 16;
  localparam int          FIN_N         = 15;
  localparam int          DEST_N        = 12;
  localparam int          TSIG_N        = 15;
  localparam int          TSRC_N        = 22;
  localparam logic [3:0]  PIN_STAR      = 4'hE;
  localparam logic [3:0]  PIN_BP10      = 4'hF;
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_TRIG_OE  = 8'h08;
  localparam logic [7:0]  ADDR_TSEL_LO  = 8'h0C;
  localparam logic [7:0]  ADDR_TSEL_HI  = 8'h10;
  localparam logic [7:0]  ADDR_FILT     = 8'h14;
  localparam logic [7:0]  ADDR_FRONT    = 8'h18;
  localparam logic [7:0]  ADDR_DEST0    = 8'h20;
  localparam logic [5:0]  DEST_WORD0    = 6'h08;
  // control fields
  localparam int          CTRL_EXT_BIT  = 0;
  localparam int          CTRL_SRC_LSB  = 1;
  localparam int          CTRL_C0_LSB   = 8;
  localparam int          CTRL_C1_LSB   = 10;
  localparam int          CTRL_W        = 12;
  localparam logic [3:0]  REF_BP10      = 4'h8;
  localparam logic [3:0]  REF_STAR      = 4'h9;
  localparam logic [1:0]  CSRC_TB80     = 2'h0;
  localparam logic [1:0]  CSRC_TB20     = 2'h1;
  localparam logic [1:0]  CSRC_TB100K   = 2'h2;
  // destination config fields
  localparam int          DCFG_W        = 6;
  localparam int          DCFG_INV_BIT  = 4;
  localparam int          DCFG_EDGE_BIT = 5;
  // timebase division
  localparam logic [1:0]  TB80_PER_CLK  = 2'h2;
  localparam int          TB20_DIV      = 4;
  localparam int          TB100K_DIV    = 200;
  localparam logic [7:0]  TB100K_LAST   = 8'(TB100K_DIV - 1);
  localparam int          REF10_DIV     = 4;
  localparam logic [4:0]  LOCK_WIN      = 5'h10;
  // trigger line output sources
  localparam logic [14:0] TSIG_INV_MASK = 15'h0024;
  localparam logic [4:0]  TSRC_REF10    = 5'h0F;
  localparam logic [4:0]  TSRC_CONV     = 5'h02;
  // filter settings
  localparam logic [1:0]  FSET_OFF      = 2'h0;
  localparam logic [1:0]  FSET_SHORT    = 2'h1;
  localparam logic [1:0]  FSET_MID      = 2'h2;
  localparam logic [1:0]  FSET_LONG     = 2'h3;
  localparam int          FILT_SHORT_NS = 125;
  localparam int          FILT_MID_NS   = 6425;
  localparam int          FILT_LONG_NS  = 2560000;
  localparam int          FILT_SHORT_N  = (FILT_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FILT_MID_N    = (FILT_MID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          FILT_LONG_N   = 101800;
  localparam int          FILT_CNT_W    = 17;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// file: src/tbtr_filter.sv
// tbtr_filter: programmable debounce filter for one synchronised input
`timescale 1ns/1ps
module tbtr_filter
  import tbtr_pkg::*;
#(
  parameter int LONG_N = FILT_LONG_N
)
(
  input  wire logic       aclk,    // 40 MHz filter clock
  input  wire logic       aresetn, // sync reset, active low
  input  wire logic       smp_i,   // synchronised input
  input  wire logic [1:0] set_i,   // filter setting
  output logic            filt_o   // filtered level
);
  localparam logic [FILT_CNT_W-1:0] LAST_SHORT = FILT_CNT_W'(FILT_SHORT_N - 1);
  localparam logic [FILT_CNT_W-1:0] LAST_MID   = FILT_CNT_W'(FILT_MID_N - 1);
  localparam logic [FILT_CNT_W-1:0] LAST_LONG  = FILT_CNT_W'(LONG_N - 1);

  logic [FILT_CNT_W-1:0] cnt_r;
  logic [FILT_CNT_W-1:0] last_w;

  always_comb
  begin
    last_w = LAST_LONG;
    case (set_i)
      FSET_SHORT: last_w = LAST_SHORT;
      FSET_MID:   last_w = LAST_MID;
      default:    last_w = LAST_LONG;
    endcase
  end

  // one sample per clock edge; a matching sample restarts the count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      filt_o <= 1'b0;
      cnt_r  <= '0;
    end
    else if (set_i == FSET_OFF)
    begin
      filt_o <= smp_i;
      cnt_r  <= '0;
    end
    else if (smp_i == filt_o)
    begin
      cnt_r <= '0;
    end
    else if (cnt_r >= last_w)
    begin
      filt_o <= smp_i;
      cnt_r  <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  a_filter_off_pass: assert property (@(posedge aclk) disable iff (!aresetn)
    (set_i == FSET_OFF) |=> (filt_o == $past(smp_i)))
    else $error("disabled filter did not pass input");

  a_filter_short_run: assert property (@(posedge aclk) disable iff (!aresetn)
    ($changed(filt_o) && $past(set_i) == FSET_SHORT && $past(set_i, 5) == FSET_SHORT)
    |-> ($past(smp_i, 1) == filt_o && $past(smp_i, 2) == filt_o && $past(smp_i, 3) == filt_o
         && $past(smp_i, 4) == filt_o && $past(smp_i, 5) == filt_o))
    else $error("short filter passed level without five samples");
endmodule

// file: bench/tbtr_board.sv
// model of another acquisition board sharing the trigger lines
`timescale 1ns/1ps
module tbtr_board
(
  input  wire logic       aclk,   // board oscillator
  input  wire logic       ref_en, // drive 10 MHz onto line 7
  input  wire logic [6:0] lvl,    // trigger levels, lines 0-6
  output logic      [7:0] p_o,    // line drive level
  output logic      [7:0] p_oe    // high while driving
);
  logic [1:0] div_r = 2'h0;
  always @(posedge aclk)
    div_r <= div_r + 2'h1;
  // low levels are released, the pull-down holds them
  assign p_o  = {div_r[1], lvl};
  assign p_oe = {ref_en, lvl};
endmodule

// file: bench/timebase_and_trigger_routing_tb.sv
// self-checking bench for timebases and trigger routing
`timescale 1ns/1ps
module timebase_and_trigger_routing_tb;
  import tbtr_pkg::*;
  logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, ref_en = 0;
  logic        awr, wr_, bv, arr, rv, pref, lock, t20, t100, ref10, ref10_q;
  logic [7:0]  awa = 0, ara = 0, trig_o, trig_oe, p_o, p_oe;
  logic [6:0]  lvl = 0;
  logic [31:0] wd = 0, rdata, rd_d;
  logic [1:0]  bresp, rresp, rd_r, c0, c1, wr_b;
  logic [5:0]  front_i = 0, ffo, ffoe;
  logic [14:0] tsig = 0;
  logic [11:0] dest;
  wire  [7:0]  tl = (trig_o & trig_oe) | (p_o & p_oe);
  int          miscompares = 0, n_tests = 0, k, j, s, n20, n100, a0, a1, nr;
  int          srcs[4] = '{0, 2, 5, 14};

  tbtr_top #(.FILT_LONG_CNT(20)) u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .trig_i(tl), .trig_o(trig_o),
    .trig_oe(trig_oe), .front_i(front_i), .front_fwd_o(ffo), .front_fwd_oe(ffoe), .star_i(tsig[0]),
    .bp10_i(tsig[1]), .tim_sig_i(tsig), .pll_ref_o(pref), .pll_lock_o(lock), .tb20_tick_o(t20),
    .tb100k_tick_o(t100), .ctr0_inc_o(c0), .ctr1_inc_o(c1), .ref10_o(ref10), .dest_o(dest));
  tbtr_board u_board (.aclk(aclk), .ref_en(ref_en), .lvl(lvl), .p_o(p_o), .p_oe(p_oe));

  initial
    forever #12.5 aclk = ~aclk;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
    n_tests++;
    if (v !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, v);
    end
  endtask

  // level a line should show for a selected internal source
  function automatic logic exp_line(input int src, input logic [14:0] v);
    return v[src] ^ TSIG_INV_MASK[src];
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic tmo(input int i);
    if (i >= 50)
    begin
      miscompares++;
      wrap_up();
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
      if (bv) break;
    end
    wr_b = bresp;
    br <= 1'b0;
    tmo(i);
  endtask

  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rd_d = rdata;
    rd_r = rresp;
    rr <= 1'b0;
    tmo(i);
  endtask

  task automatic cnt(input int n);
    {n20, n100, a0, a1, nr} = 0;
    ref10_q = ref10;
    repeat (n)
    begin
      @(posedge aclk);
      n20 += t20;
      n100 += t100;
      a0 += c0;
      a1 += c1;
      nr += (ref10 && !ref10_q);
      ref10_q = ref10;
    end
  endtask

  initial
  begin
    s = $urandom(55633);
    front_i <= 6'($urandom);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL); chk("ctrl", 0, rd_d);
    rd(ADDR_FILT); chk("filt", 0, rd_d);
    rd(8'hFC); chk("resp", RESP_SLVERR, rd_r);
    wr(8'h1C, 32'h0);
    chk("bresp_err", RESP_SLVERR, wr_b);
    wr(ADDR_CTRL, 32'h0000_0100);
    chk("bresp", RESP_OKAY, wr_b);
    cnt(400);
    chk("ctr0_20", 200, a0);
    chk("ctr1_80", 800, a1);
    wr(ADDR_CTRL, 32'h0000_0200);
    cnt(800);
    chk("tb20", 400, n20);
    chk("tb100k", 2, n100);
    chk("ctr0", 2, a0);
    chk("ctr1", 1600, a1);
    chk("ref10", 200, nr);
    k = $urandom % 4;
    wr(ADDR_TRIG_OE, 32'h1 << k);
    for (j = 0; j < 4; j++)
    begin
      tsig <= 15'($urandom);
      wr(ADDR_TSEL_LO, srcs[j] << (8 * k));
      repeat (3) @(posedge aclk);
      chk("line", exp_line(srcs[j], tsig), tl[k]);
    end
    j = 4 + $urandom % 3;
    wr(ADDR_FILT, 32'h1 << (2 * j));
    wr(ADDR_DEST0, j);
    wr(ADDR_FRONT, 8 | j);
    lvl[j] <= 1'b1;
    repeat (4) @(posedge aclk);
    lvl[j] <= 1'b0;
    chk("fwd", 2'h3, {ffoe[0], ffo[0]});
    repeat (12) @(posedge aclk);
    chk("glitch", 0, dest[0]);
    lvl[j] <= 1'b1;
    repeat (12) @(posedge aclk);
    chk("pass", 1, dest[0]);
    wr(ADDR_DEST0 + 8'h04, 32'h30 | j);
    lvl[j] <= 1'b0;
    nr = 0;
    repeat (16)
    begin
      @(posedge aclk);
      nr += dest[1];
    end
    chk("edge_inv", 1, nr);
    chk("fall", 0, dest[0]);
    wr(ADDR_CTRL, 32'h0000_000F);
    ref_en <= 1'b1;
    repeat (40) @(posedge aclk);
    chk("lock", 1, lock);
    cnt(40);
    chk("ext_tb20", 20, n20);
    ref_en <= 1'b0;
    repeat (40) @(posedge aclk);
    cnt(100);
    chk("stopped", 0, n20);
    tsig <= 15'h0002;
    wr(ADDR_CTRL, 32'h0000_0010);
    repeat (4) @(posedge aclk);
    chk("bp10", 1, pref);
    tsig <= 15'h0001;
    wr(ADDR_CTRL, 32'h0000_0012);
    repeat (4) @(posedge aclk);
    chk("star", 1, pref);
    wrap_up();
  end

  initial
  begin
    #2500000;
    miscompares++;
    wrap_up();
  end
endmodule
